// *** design/gpt_consts.svh ***
// Register offsets, field positions, reset values and timer constants of the general-purpose port.
`ifndef GPT_CONSTS_SVH
`define GPT_CONSTS_SVH
`define GPT_CTRL_OFFSET   8'h3C
`define GPT_TOE_BIT       15
`define GPT_DIR_LSB       8
`define GPT_VAL_LSB       0
`define GPT_CTRL_RESET    16'h0000
`define GPT_CTRL_WMASK    16'h8F0F
`define GPT_TIM_OFFSET    8'h24
`define GPT_PRD_OFFSET    8'h25
`define GPT_TCR_OFFSET    8'h26
`define GPT_PRD_RESET     16'hFFFF
`define GPT_TCR_RESET     16'h0000
`define GPT_TCR_STOP_BIT  4
`define GPT_TCR_RELOAD_BIT 5
`define GPT_TCR_DIS_BIT   15
`define GPT_TCR_PSC_LSB   0
`define GPT_TCR_TDD_LSB   6
`define GPT_TCR_WMASK     16'h83DF
`define GPT_SHARED_PIN    3
`define GPT_BRANCH_PIN    2
`endif

// *** design/gpt_pkg.sv ***
// Types shared by the general-purpose port with timer output.
package gpt_pkg;
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } gpt_bus_req_t;
  typedef struct packed
  {
    logic [3:0] value;
    logic [3:0] enable;
  } gpt_pin_drive_t;
endpackage

// *** design/gpt_port.sv ***
// Four-pin general-purpose port with a down-counting timer whose pulse may drive pin 3.
//
// Function
// (R1) One port control register at data offset 0x3c governs the four pins.
// (R2) Timer output enable at bit 15 clear keeps pin 3 ordinary; resets clear.
// (R3) With timer output enable set, pin 3 drives timer pulse; its data bit reads it.
// (R4) Bits 14-12 and 7-4 are reserved and affect no port logic.
// (R5) Bits 11-8 are per-pin directions; clear means input, the reset state.
// (R6) Bits 3-0 drive output pins and read back sampled input levels.
// (R7) Pin 2 stays ordinary; as input its level feeds the branch condition.
// (R8) Timer has a 16-bit down-counter and 4-bit prescaler, clocked by the cpu clock.
// (R9) Each decrement to zero raises timer interrupt and produces output pulse.
// (R10) Software can stop, restart, reset and disable the timer through control bits.
// (R11) Timer pulse reaches pin 3 only while external interface select is low.
// (R12) Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "gpt_consts.svh"
module gpt_port #(
  parameter int PinCount = 4
)(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire gpt_pkg::gpt_bus_req_t   busReq,
  output logic [15:0]                  busRdata,
  input  wire logic [PinCount-1:0]     pinIn,
  output logic [PinCount-1:0]          pinOut,
  output logic [PinCount-1:0]          pinOe,
  input  wire logic                    externalInterfaceSelect,
  output logic                         branchInputCondition,
  output logic                         timerIrq,
  output logic                         timerOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [PinCount-1:0] pinMeta_q;
  logic [PinCount-1:0] pinSync_q;
  logic                xioMeta_q;
  logic                xioSync_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      xioMeta_q <= 1'b0;
      xioSync_q <= 1'b0;
    end
    else
    begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
      xioMeta_q <= externalInterfaceSelect;
      xioSync_q <= xioMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  logic [15:0] ctrl_q;
  logic [15:0] period_q;
  logic [15:0] tcr_q;
  logic [15:0] count_q;
  logic [3:0]  psc_q;

  wire selCtrl  = (busReq.addr == `GPT_CTRL_OFFSET); // [R1]
  wire selTim   = (busReq.addr == `GPT_TIM_OFFSET);
  wire selPrd   = (busReq.addr == `GPT_PRD_OFFSET);
  wire selTcr   = (busReq.addr == `GPT_TCR_OFFSET);
  wire wrCtrl   = busReq.wr && selCtrl;
  wire wrTim    = busReq.wr && selTim;
  wire wrPrd    = busReq.wr && selPrd;
  wire wrTcr    = busReq.wr && selTcr;

  wire [PinCount-1:0] dirBits = ctrl_q[`GPT_DIR_LSB +: PinCount]; // [R5]
  wire [PinCount-1:0] valBits = ctrl_q[`GPT_VAL_LSB +: PinCount];
  wire                toutEn  = ctrl_q[`GPT_TOE_BIT];
  wire                tcrStop = tcr_q[`GPT_TCR_STOP_BIT];
  wire                tcrDis  = tcr_q[`GPT_TCR_DIS_BIT];
  wire [3:0]          tddq    = tcr_q[`GPT_TCR_TDD_LSB +: 4];
  wire                tcrReload = wrTcr && busReq.wdata[`GPT_TCR_RELOAD_BIT];

  // Timer pulse routed to the shared pin only while external interface select is low.
  wire toutRoute = toutEn && !xioSync_q; // [R3] [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Port control register; reserved bits never stored.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `GPT_CTRL_RESET; // [R2] [R5]
    else if (wrCtrl)
      ctrl_q <= busReq.wdata & `GPT_CTRL_WMASK; // [R4] [R12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer: prescaler counts down from its reload, then the counter steps.
  wire running   = !tcrStop && !tcrDis;
  wire pscZero   = (psc_q == 4'h0);
  wire stepCount = running && pscZero;
  wire cntZero   = (count_q == 16'h0000);
  wire hitZero   = stepCount && (count_q == 16'h0001) && !tcrReload && !wrTim; // [R9]

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tcr_q <= `GPT_TCR_RESET;
    else if (wrTcr)
      tcr_q <= busReq.wdata & `GPT_TCR_WMASK; // [R10]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      period_q <= `GPT_PRD_RESET;
    else if (wrPrd)
      period_q <= busReq.wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      psc_q <= '0;
    else if (tcrReload || !running || pscZero)
      psc_q <= tcrReload ? busReq.wdata[`GPT_TCR_TDD_LSB +: 4] : tddq; // [R8]
    else
      psc_q <= psc_q - 4'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= `GPT_PRD_RESET;
    else if (tcrReload)
      count_q <= period_q; // [R10]
    else if (wrTim)
      count_q <= busReq.wdata;
    else if (stepCount)
      count_q <= cntZero ? period_q : count_q - 16'h0001; // [R8]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timerIrq <= 1'b0;
      timerOut <= 1'b0;
    end
    else
    begin
      timerIrq <= hitZero; // [R9]
      timerOut <= hitZero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and branch condition.
  gpt_pkg::gpt_pin_drive_t drive;
  always_comb
  begin
    drive.value  = valBits;
    drive.enable = dirBits; // [R5] [R6]
    if (toutRoute)
    begin
      drive.value[`GPT_SHARED_PIN]  = timerOut; // [R3]
      drive.enable[`GPT_SHARED_PIN] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOut               <= '0;
      pinOe                <= '0;
      branchInputCondition <= 1'b0;
    end
    else
    begin
      pinOut               <= drive.value;
      pinOe                <= drive.enable;
      branchInputCondition <= dirBits[`GPT_BRANCH_PIN] ? 1'b0 : pinSync_q[`GPT_BRANCH_PIN]; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: inputs show pin level, outputs show the written bit; pin 3 shows the timer pulse while timer output enable is set.
  logic [PinCount-1:0] readVal;
  always_comb
  begin
    readVal = (dirBits & valBits) | (~dirBits & pinSync_q); // [R6]
    if (toutEn)
      readVal[`GPT_SHARED_PIN] = timerOut; // [R3]
  end

  wire [15:0] ctrlRead = {toutEn, 3'h0, dirBits, 4'h0, readVal}; // [R12]
  wire [15:0] rdNext   = !busReq.rd ? 16'h0000 :
                         selCtrl ? ctrlRead :
                         selTim  ? count_q :
                         selPrd  ? period_q :
                         selTcr  ? tcr_q : 16'h0000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busRdata <= '0;
    else
      busRdata <= rdNext;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    busReq.rd && selCtrl |=> (busRdata[14:12] == 3'h0) && (busRdata[7:4] == 4'h0))
    else $error("Reserved bits read non-zero.");
  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    wrCtrl |=> ctrl_q == ($past(busReq.wdata) & `GPT_CTRL_WMASK))
    else $error("Control write not stored.");
  AST_TIMER_OUTPUT_ENABLE_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    toutRoute |=> pinOe[`GPT_SHARED_PIN] && pinOut[`GPT_SHARED_PIN] == $past(timerOut))
    else $error("Timer pulse not on shared pin.");
  AST_TIMER_OUTPUT_ENABLE_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    xioSync_q && !dirBits[`GPT_SHARED_PIN] |=> !pinOe[`GPT_SHARED_PIN])
    else $error("Timer drove pin in interface mode.");
  AST_PLAIN_PIN3: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    !toutEn |=> pinOe[`GPT_SHARED_PIN] == $past(dirBits[`GPT_SHARED_PIN]))
    else $error("Pin 3 not ordinary when timer output off.");
  AST_DIR_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    1'b1 |=> pinOe[1:0] == $past(dirBits[1:0]) && pinOut[1:0] == $past(valBits[1:0]))
    else $error("Direction or value mismatch.");
  AST_BRANCH: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    !dirBits[`GPT_BRANCH_PIN] |=> branchInputCondition == $past(pinSync_q[`GPT_BRANCH_PIN]))
    else $error("Branch condition lost pin level.");
  AST_DECREMENT: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    stepCount && !cntZero && !tcrReload && !wrTim |=> count_q == $past(count_q) - 16'h0001)
    else $error("Counter did not decrement.");
  AST_ZERO_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    hitZero |=> timerIrq && timerOut ##1 !timerIrq)
    else $error("Missing one-cycle timer pulse.");
  AST_STOP_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    tcrStop && !wrTim && !tcrReload |=> count_q == $past(count_q))
    else $error("Stopped timer moved.");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pins and the read path.
  AST_TIMER_OUTPUT_ENABLE_READ: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    busReq.rd && selCtrl && toutEn |=> busRdata[`GPT_SHARED_PIN] == $past(timerOut))
    else $error("Pin 3 data bit does not show the timer pulse.");
  AST_INPUT_READ: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    busReq.rd && selCtrl && !dirBits[0] |=> busRdata[0] == $past(pinSync_q[0]))
    else $error("Input pin read does not show its level.");
  AST_OUTPUT_READ: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    busReq.rd && selCtrl && dirBits[1] |=> busRdata[1] == $past(valBits[1]))
    else $error("Output pin read does not show its data bit.");
  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    busReq.rd && !selCtrl && !selTim && !selPrd && !selTcr |=> busRdata == 16'h0000)
    else $error("Unmapped read returned data.");
  AST_RESERVED_STORE: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    1'b1 |-> (ctrl_q & ~`GPT_CTRL_WMASK) == 16'h0000)
    else $error("Reserved control bits were stored.");
  AST_PLAIN_VALUE: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    !toutRoute |=> pinOut[`GPT_SHARED_PIN] == $past(valBits[`GPT_SHARED_PIN]))
    else $error("Pin 3 value not from its data bit.");
  AST_XIO_DIR: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    xioSync_q |=> pinOe[`GPT_SHARED_PIN] == $past(dirBits[`GPT_SHARED_PIN]))
    else $error("Pin 3 enable not from its direction in interface mode.");
  AST_BRANCH_OUT: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    dirBits[`GPT_BRANCH_PIN] |=> !branchInputCondition)
    else $error("Branch condition set while pin 2 is an output.");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the timer.
  AST_TCR_STORE: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    wrTcr |=> tcr_q == ($past(busReq.wdata) & `GPT_TCR_WMASK))
    else $error("Timer control write not stored.");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    tcrReload |=> count_q == $past(period_q))
    else $error("Reload did not copy the period.");
  AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    stepCount && cntZero && !tcrReload && !wrTim |=> count_q == $past(period_q))
    else $error("Counter did not wrap to the period.");
  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    !stepCount && !tcrReload && !wrTim |=> count_q == $past(count_q))
    else $error("Counter moved without a step.");
  AST_PSC_RELOAD: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    running && pscZero && !tcrReload |=> psc_q == $past(tddq))
    else $error("Prescaler did not reload.");
  AST_DISABLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    tcrDis && !wrTim && !tcrReload |=> count_q == $past(count_q))
    else $error("Disabled timer moved.");
  AST_IRQ_ONLY_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    !hitZero |=> !timerIrq)
    else $error("Timer interrupt without reaching zero.");
  AST_IRQ_OUT_SAME: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    1'b1 |-> timerIrq == timerOut)
    else $error("Timer interrupt and pulse differ.");

  // Main scenarios worth seeing.
  COV_TIMER_OUTPUT_ENABLE_PIN: cover property (@(posedge clk) disable iff (!rst_n) toutRoute && timerOut);
  COV_ZERO: cover property (@(posedge clk) disable iff (!rst_n) hitZero);
  COV_BRANCH: cover property (@(posedge clk) disable iff (!rst_n) branchInputCondition);
  COV_RELOAD: cover property (@(posedge clk) disable iff (!rst_n) tcrReload);
  COV_STOP: cover property (@(posedge clk) disable iff (!rst_n) tcrStop);

endmodule

// *** verification/gpt_pin_partner.sv ***
// Outside circuitry on the four pins: drives every pin that the port leaves free.
`timescale 1ns/1ps
module gpt_pin_partner (
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  input  wire logic [3:0] extLevel,
  output logic [3:0]      pinIn
);
  // A driven pin shows the port's value; a free pin shows the level chosen outside.
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// *** verification/gpio_port_with_timer_out_test.sv ***
// Self-checking bench for the general-purpose port with timer output.
`timescale 1ns/1ps
module gpio_port_with_timer_out_test;
  logic                  clk;
  logic                  rst_n;
  gpt_pkg::gpt_bus_req_t busReq;
  logic [15:0]           busRdata;
  logic [3:0]            pinIn;
  logic [3:0]            pinOut;
  logic [3:0]            pinOe;
  logic [3:0]            extLevel;
  logic                  external_interface_select;
  logic                  branch;
  logic                  timerIrq;
  logic                  timerOut;
  logic [15:0]           rdv;
  logic [15:0]           ctrlModel;
  integer                err_total;
  integer                cmp_count;
  integer                seed;
  integer                prd;
  integer                irqs;
  integer                pins;
  integer                outs;

  gpt_port uut (.clk(clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .externalInterfaceSelect(external_interface_select), .branchInputCondition(branch),
    .timerIrq(timerIrq), .timerOut(timerOut));
  gpt_pin_partner pins_u (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    busReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) #1;
    busReq.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) #1;
    busReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk) #1;
    busReq.rd = 1'b0;
    d = busRdata;
  endtask

  // Counts timer pulses and high cycles of pin 3 over n cycles.
  task automatic pulses(input integer n);
    irqs = 0;
    pins = 0;
    outs = 0;
    repeat (n)
    begin
      @(posedge clk) #1;
      irqs += (timerIrq === 1'b1);
      outs += (timerOut === 1'b1);
      pins += (pinOut[3] === 1'b1);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The whole sequence needs well under two thousand cycles.
  initial
  begin
    #100000;
    err_total++;
    tally_and_finish;
  end

  initial
  begin
    seed = 32'hd3e4;
    err_total = 0;
    cmp_count = 0;
    busReq = '0;
    extLevel = 4'h0;
    external_interface_select = 1'b0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(8'h3C, rdv); chk("ctrl reset", 16'h0000, rdv);
    rd(8'h3D, rdv); chk("unmapped read", 16'h0000, rdv);
    ctrlModel = (16'($random(seed)) & 16'h0F0F) | 16'h7FF0;
    wr(8'h3C, ctrlModel);
    ctrlModel &= 16'h0F0F;
    // Free pins sit low outside, so an input pin reads zero whatever its data bit holds.
    rd(8'h3C, rdv);
    chk("ctrl readback", {4'h0, ctrlModel[11:8], 4'h0, ctrlModel[3:0] & ctrlModel[11:8]}, rdv);
    chk("pin drive", {8'h00, ctrlModel[11:8], ctrlModel[3:0]}, {8'h00, pinOe, pinOut});
    $display("test outputs done");
    wr(8'h3C, 16'h0000);
    repeat (4)
    begin
      extLevel = 4'($random(seed));
      repeat (4) @(posedge clk);
      rd(8'h3C, rdv); chk("pin sample", {12'h000, extLevel}, rdv);
      chk("branch", {15'h0000, extLevel[2]}, {15'h0000, branch});
    end
    wr(8'h3C, 16'h0400);
    extLevel = 4'hF;
    repeat (4) @(posedge clk);
    rd(8'h3C, rdv); chk("mixed dirs", 16'h040B, rdv);
    chk("branch output", 16'h0000, {15'h0000, branch});
    $display("test inputs done");
    prd = 2 + ({$random(seed)} % 4);
    wr(8'h25, 16'(prd));
    wr(8'h24, 16'(prd));
    wr(8'h26, 16'h0000);
    repeat (prd + 2) @(posedge clk);
    pulses(5 * (prd + 1)); chk("irq count", 16'h0005, 16'(irqs));
    chk("out count", 16'h0005, 16'(outs));
    wr(8'h26, 16'h0060);
    repeat (4) @(posedge clk);
    pulses(10 * (prd + 1)); chk("prescaled irqs", 16'h0005, 16'(irqs));
    wr(8'h26, 16'h0010);
    pulses(20); chk("stopped irqs", 16'h0000, 16'(irqs));
    wr(8'h26, 16'h0000);
    repeat (prd + 2) @(posedge clk);
    pulses(prd + 1); chk("restart irqs", 16'h0001, 16'(irqs));
    wr(8'h26, 16'h8000);
    pulses(20); chk("disabled irqs", 16'h0000, 16'(irqs));
    wr(8'h26, 16'h0000);
    $display("test timer done");
    wr(8'h3C, 16'h8000);
    repeat (4) @(posedge clk);
    pulses(5 * (prd + 1)); chk("pin3 pulses", 16'h0005, 16'(pins));
    chk("pin3 enable", 16'h0001, {15'h0000, pinOe[3]});
    external_interface_select = 1'b1;
    repeat (4) @(posedge clk);
    pulses(5 * (prd + 1)); chk("pin3 blocked", 16'h0000, 16'(pins));
    chk("pin3 free", 16'h0000, {15'h0000, pinOe[3]});
    external_interface_select = 1'b0;
    wr(8'h3C, 16'h0808);
    repeat (4) @(posedge clk);
    pulses(5 * (prd + 1)); chk("pin3 plain", 16'(5 * (prd + 1)), 16'(pins));
    $display("test timer pin done");
    tally_and_finish;
  end
endmodule
